// ==== core/fma_arbiter.sv ====
// Frame memory arbiter with memory controller: grants the shared frame memory
// to the host or to the internal bus engine and drives the memory strobes.
// Assumes all inputs synchronous to i_clk_sys; the host and engine drop their
// access request after the done pulse before starting another.
`timescale 1ns/1ps
module fma_arbiter
    import fma_pkg::*;
(
    input  wire logic       i_clk_sys,
    input  wire logic       i_sys_rst,
    input  wire logic [1:0] i_arbitration_strategy,
    input  wire logic [1:0] i_waitstate_count,
    input  wire logic       i_class1_mode,
    input  wire logic       i_host_memory_request,
    input  wire logic       i_host_rd,
    input  wire logic       i_host_wr,
    input  wire logic       i_host_reg_sel,
    input  wire logic       i_eng_req,
    input  wire logic       i_eng_high_prio,
    input  wire logic       i_eng_access,
    input  wire logic       i_eng_write,
    input  wire logic       i_mem_ready,
    output logic            o_host_done,
    output logic            o_reg_rd,
    output logic            o_reg_wr,
    output logic            o_eng_grant,
    output logic            o_eng_done,
    output logic            o_addr_grant,
    output logic            o_data_buf_en,
    output logic            o_memory_chip_select,
    output logic            o_memory_read_strobe,
    output logic            o_memory_write_strobe
);
    fma_state_e state_ff;
    fma_state_e nxt_state;
    logic [1:0] strat_ff;
    logic       acc_active_ff;
    logic       acc_strobe_ff;
    logic       acc_eng_ff;
    logic       acc_write_ff;
    logic       acc_reg_ff;
    logic       acc_hold_ff;
    logic       addr_grant_ff;
    logic       data_buf_en_ff;
    logic       cs_ff;
    logic       rd_ff;
    logic       wr_ff;
    logic       reg_rd_ff;
    logic       reg_wr_ff;
    logic       host_done_ff;
    logic       eng_done_ff;
    logic       st_cpu;
    logic       st_eng;
    logic       eng_first;
    logic       leave_cpu;
    logic       leave_eng;
    logic       host_start;
    logic       eng_start;
    logic       host_wants;

    fma_wait_if wif ();

    fma_wait u_wait (
        .i_clk_sys (i_clk_sys),
        .i_sys_rst (i_sys_rst),
        .wif       (wif)
    );

    // True when the engine outranks the host under the latched strategy
    function automatic logic eng_outranks(input logic [1:0] strat, input logic hi);
        eng_outranks = (strat == FMA_STRAT_ENG_PRIO) ||
                       (strat == FMA_STRAT_MIXED && hi);
    endfunction : eng_outranks

    assign st_cpu     = (state_ff == FMA_ST_CPU);
    assign st_eng     = (state_ff == FMA_ST_ENG);
    assign host_wants = i_host_memory_request;
    assign eng_first  = eng_outranks(strat_ff, i_eng_high_prio);

    // Switch decisions, never while an access is open
    always_comb begin
        leave_cpu = 1'b0;
        leave_eng = 1'b0;
        if (st_cpu && i_eng_req && !acc_active_ff && strat_ff != FMA_STRAT_LOCK) begin
            leave_cpu = eng_first || !host_wants;
        end
        if (st_eng && !acc_active_ff) begin
            if (strat_ff == FMA_STRAT_LOCK) begin
                leave_eng = 1'b1;
            end else if (!i_eng_req) begin
                leave_eng = host_wants || !i_class1_mode;
            end else begin
                leave_eng = host_wants && !eng_first;
            end
        end
    end

    // Access starts are blocked while ownership is about to move
    assign host_start = st_cpu && !leave_cpu && host_wants && (i_host_rd ^ i_host_wr) &&
                        !acc_active_ff && !acc_hold_ff;
    assign eng_start  = st_eng && !leave_eng && i_eng_access && !acc_active_ff &&
                        !acc_hold_ff;

    // Next state; guard states keep grant and host drivers apart
    always_comb begin
        case (state_ff)
            FMA_ST_CPU:    nxt_state = leave_cpu ? FMA_ST_TO_ENG : FMA_ST_CPU;
            FMA_ST_TO_ENG: nxt_state = FMA_ST_ENG;
            FMA_ST_ENG:    nxt_state = leave_eng ? FMA_ST_TO_CPU : FMA_ST_ENG;
            FMA_ST_TO_CPU: nxt_state = FMA_ST_CPU;
            default:       nxt_state = FMA_ST_CPU;
        endcase
    end

    // Arbiter state; initial owner follows the class strap
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            state_ff <= i_class1_mode ? FMA_ST_ENG : FMA_ST_CPU;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Strategy latched only between accesses
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            strat_ff <= FMA_STRAT_RST;
        end else if (!acc_active_ff) begin
            strat_ff <= i_arbitration_strategy;
        end
    end

    // Access sequencer: select phase, then strobe phase until the timer ends it
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            acc_active_ff <= 1'b0;
            acc_strobe_ff <= 1'b0;
            acc_eng_ff    <= 1'b0;
            acc_write_ff  <= 1'b0;
            acc_reg_ff    <= 1'b0;
        end else if (host_start || eng_start) begin
            acc_active_ff <= 1'b1;
            acc_strobe_ff <= 1'b0;
            acc_eng_ff    <= eng_start;
            acc_write_ff  <= eng_start ? i_eng_write : i_host_wr;
            acc_reg_ff    <= host_start && i_host_reg_sel;
        end else if (wif.done) begin
            acc_active_ff <= 1'b0;
            acc_strobe_ff <= 1'b0;
        end else if (acc_active_ff) begin
            acc_strobe_ff <= 1'b1;
        end
    end

    // Completed access waits for its requester to drop the request
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            acc_hold_ff <= 1'b0;
        end else if (wif.done) begin
            acc_hold_ff <= 1'b1;
        end else if (acc_eng_ff ? !i_eng_access : !(i_host_rd || i_host_wr)) begin
            acc_hold_ff <= 1'b0;
        end
    end

    // Timer hookup; waitstates apply to every access type
    assign wif.start     = acc_active_ff && !acc_strobe_ff && !wif.busy;
    assign wif.is_reg    = acc_reg_ff;
    assign wif.mem_ready = i_mem_ready;
    assign wif.ws        = i_waitstate_count;

    // Pin drivers: grant only in engine state, host buffers only in CPU state
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            addr_grant_ff  <= 1'b0;
            data_buf_en_ff <= 1'b0;
        end else begin
            addr_grant_ff  <= (nxt_state == FMA_ST_ENG);
            data_buf_en_ff <= (nxt_state == FMA_ST_CPU) && host_wants;
        end
    end

    // Memory strobes: host chip select follows its request except on register accesses; engine select and all read/write strobes are generated
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            cs_ff     <= 1'b0;
            rd_ff     <= 1'b0;
            wr_ff     <= 1'b0;
            reg_rd_ff <= 1'b0;
            reg_wr_ff <= 1'b0;
        end else begin
            cs_ff     <= (st_cpu && host_wants && !i_host_reg_sel && !leave_cpu) ||
                         (acc_active_ff && acc_eng_ff && !wif.done);
            rd_ff     <= acc_strobe_ff && !wif.done && !acc_reg_ff && !acc_write_ff;
            wr_ff     <= acc_strobe_ff && !wif.done && !acc_reg_ff && acc_write_ff;
            reg_rd_ff <= acc_strobe_ff && wif.done && acc_reg_ff && !acc_write_ff;
            reg_wr_ff <= acc_strobe_ff && wif.done && acc_reg_ff && acc_write_ff;
        end
    end

    // Completion pulses to each requester
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            host_done_ff <= 1'b0;
            eng_done_ff  <= 1'b0;
        end else begin
            host_done_ff <= wif.done && !acc_eng_ff;
            eng_done_ff  <= wif.done && acc_eng_ff;
        end
    end

    assign o_host_done           = host_done_ff;
    assign o_reg_rd              = reg_rd_ff;
    assign o_reg_wr              = reg_wr_ff;
    assign o_eng_grant           = st_eng;
    assign o_eng_done            = eng_done_ff;
    assign o_addr_grant          = addr_grant_ff;
    assign o_data_buf_en         = data_buf_en_ff;
    assign o_memory_chip_select  = cs_ff;
    assign o_memory_read_strobe  = rd_ff;
    assign o_memory_write_strobe = wr_ff;

    // Helper: strobe length of the current memory access
    logic [3:0] stb_len_ff;
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || !(rd_ff || wr_ff)) begin
            stb_len_ff <= 4'h0;
        end else if (stb_len_ff != 4'hf) begin
            stb_len_ff <= stb_len_ff + 4'h1;
        end
    end

    sequence s_to_eng;
        state_ff == FMA_ST_TO_ENG ##1 state_ff == FMA_ST_ENG;
    endsequence
    sequence s_to_cpu;
        state_ff == FMA_ST_TO_CPU ##1 state_ff == FMA_ST_CPU;
    endsequence

    a_grant_guard: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        !(o_addr_grant && o_data_buf_en) && (!$rose(o_data_buf_en) || !$past(o_addr_grant)))
        else $error("grant and host drivers overlap");
    a_select_leads: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        ($rose(o_memory_read_strobe) || $rose(o_memory_write_strobe)) |->
        $past(o_memory_chip_select))
        else $error("strobe without prior chip select");
    a_min_waits: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        ($fell(o_memory_read_strobe) || $fell(o_memory_write_strobe)) |->
        ($past(stb_len_ff) >= {2'h0, i_waitstate_count}))
        else $error("strobe shorter than waitstates");
    a_access_stays: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (acc_active_ff && st_eng) |=> st_eng)
        else $error("owner switched mid access");
    a_cpu_priority: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (st_eng && strat_ff == FMA_STRAT_CPU_PRIO && host_wants && !acc_active_ff)
        |=> s_to_cpu)
        else $error("host request not honoured");
    a_host_series: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (st_cpu && strat_ff == FMA_STRAT_CPU_PRIO && host_wants) |=> st_cpu)
        else $error("engine broke host series");
    a_eng_suspends: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (st_cpu && strat_ff == FMA_STRAT_ENG_PRIO && i_eng_req && !acc_active_ff)
        |=> s_to_eng)
        else $error("engine request not honoured");
    a_lock_holds: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (st_cpu && strat_ff == FMA_STRAT_LOCK) |=> st_cpu && !o_eng_grant)
        else $error("engine reached locked memory");
    a_high_prio: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (st_eng && strat_ff == FMA_STRAT_MIXED && i_eng_req && i_eng_high_prio) |=> st_eng)
        else $error("host broke engine transfer");
    a_voluntary: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (st_eng && !i_eng_req && !i_class1_mode && !acc_active_ff) |=> s_to_cpu)
        else $error("no voluntary return");
    a_strat_stable: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        acc_active_ff |=> $stable(strat_ff))
        else $error("strategy changed mid access");

endmodule : fma_arbiter

// ==== core/fma_pkg.sv ====
// Constants and types shared by the frame memory arbiter and its waitstate timer.
// Assumes one synchronous clock domain; no bus, all configuration arrives on ports.
package fma_pkg;

    // Strategy field encodings
    localparam logic [1:0] FMA_STRAT_CPU_PRIO = 2'h0;
    localparam logic [1:0] FMA_STRAT_ENG_PRIO = 2'h1;
    localparam logic [1:0] FMA_STRAT_LOCK     = 2'h2;
    localparam logic [1:0] FMA_STRAT_MIXED    = 2'h3;

    // Reset values
    localparam logic [1:0] FMA_STRAT_RST      = 2'h0;
    localparam logic [1:0] FMA_WS_RST         = 2'h0;
    localparam logic [2:0] FMA_CNT_RST        = 3'h0;

    // Clock rate, for reference by timing figures
    localparam int FMA_CLK_MHZ = 200;

    // Arbiter states, one-hot
    typedef enum logic [3:0] {
        FMA_ST_CPU    = 4'h1,
        FMA_ST_TO_ENG = 4'h2,
        FMA_ST_ENG    = 4'h4,
        FMA_ST_TO_CPU = 4'h8
    } fma_state_e;

endpackage : fma_pkg

// ==== core/fma_wait.sv ====
// Waitstate timer: holds an access open for the minimum waitstate count
// and then until the memory reports ready. Register accesses skip the ready.
`timescale 1ns/1ps
module fma_wait
    import fma_pkg::*;
(
    input  wire logic i_clk_sys,
    input  wire logic i_sys_rst,
    fma_wait_if.tmr   wif
);
    logic       run_ff;
    logic [2:0] cnt_ff;
    logic [1:0] ws_ff;
    logic       reg_ff;

    // Done once the strobe has run one cycle past the waitstate count and the
    // target is ready; the strobe spans ws+1 cycles, so each waitstate adds one
    assign wif.done = run_ff && (cnt_ff > {1'b0, ws_ff}) && (reg_ff || wif.mem_ready);
    assign wif.busy = run_ff;

    // Count strobe cycles; settings are latched so a change mid-access has no effect
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            run_ff <= 1'b0;
            cnt_ff <= FMA_CNT_RST;
            ws_ff  <= FMA_WS_RST;
            reg_ff <= 1'b0;
        end else if (wif.start) begin
            run_ff <= 1'b1;
            cnt_ff <= FMA_CNT_RST;
            ws_ff  <= wif.ws;
            reg_ff <= wif.is_reg;
        end else if (wif.done) begin
            run_ff <= 1'b0;
        end else if (run_ff && cnt_ff != 3'h7) begin
            cnt_ff <= cnt_ff + 3'h1; // Saturates while waiting on a slow memory
        end
    end

endmodule : fma_wait

// ==== core/fma_wait_if.sv ====
// Interface between the access sequencer and the waitstate timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface fma_wait_if;
    logic       start;     // Pulse: strobe phase begins
    logic       is_reg;    // Access targets internal registers
    logic       mem_ready; // Memory side ready, active high
    logic [1:0] ws;        // Minimum waitstates
    logic       done;      // Pulse: access may complete
    logic       busy;      // Timer running

    modport seq (output start, output is_reg, output mem_ready, output ws,
                 input done, input busy);
    modport tmr (input start, input is_reg, input mem_ready, input ws,
                 output done, output busy);
endinterface : fma_wait_if

// ==== verif/fma_mem_model.sv ====
// Frame memory ready model for the arbiter bench.
// Assumes strobes come from the arbiter, active high, on the system clock.
`timescale 1ns/1ps
module fma_mem_model (
    input  wire logic       i_clk_sys,
    input  wire logic       i_sys_rst,
    input  wire logic       i_memory_chip_select,
    input  wire logic       i_memory_read_strobe,
    input  wire logic       i_memory_write_strobe,
    input  wire logic [2:0] i_delay,
    output logic            o_mem_ready
);
    logic       strobe;
    logic [2:0] wait_ff;
    logic [2:0] nxt_wait;

    // Strobe cycles seen so far; saturates so a long access stays ready
    assign strobe   = i_memory_read_strobe || i_memory_write_strobe;
    assign nxt_wait = (wait_ff == 3'h7) ? wait_ff : wait_ff + 3'h1;
    always_ff @(posedge i_clk_sys) begin
        wait_ff <= (i_sys_rst || !strobe) ? 3'h0 : nxt_wait;
    end

    // Ready only inside a selected strobe phase, never left high between accesses
    assign o_mem_ready = i_memory_chip_select && strobe && (wait_ff >= i_delay);
endmodule : fma_mem_model

// ==== verif/frame_memory_arbiter_test.sv ====
// Self-checking bench for the frame memory arbiter.
// Assumes inputs change at the falling edge and a ready model on the memory side.
`timescale 1ns/1ps
module frame_memory_arbiter_test;
    import fma_pkg::*;
    logic       clk = 0, rst = 1, cls1 = 0, hreq = 0, hrd = 0, hwr = 0, hreg = 0;
    logic       ereq = 0, ehp = 0, eacc = 0, ewr = 0, rdy, ok, r_rw;
    logic [1:0] strat = FMA_STRAT_CPU_PRIO, ws = 2'h0;
    logic [2:0] mdly = 3'h0;
    logic       hdone, rrd, rwr, egnt, edone, agnt, dbuf, cs, mrd, mwr;
    logic       seen_cs, seen_rd, seen_wr, p_gnt, p_str, p_cs, p_rd, p_wr;
    int         n_mismatch = 0, compares = 0, cycles = 0, lat, lat_prev, lat0;

    always #2.5 clk = ~clk;

    fma_arbiter dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_arbitration_strategy(strat),
        .i_waitstate_count(ws), .i_class1_mode(cls1), .i_host_memory_request(hreq),
        .i_host_rd(hrd), .i_host_wr(hwr), .i_host_reg_sel(hreg), .i_eng_req(ereq),
        .i_eng_high_prio(ehp), .i_eng_access(eacc), .i_eng_write(ewr), .i_mem_ready(rdy),
        .o_host_done(hdone), .o_reg_rd(rrd), .o_reg_wr(rwr), .o_eng_grant(egnt),
        .o_eng_done(edone), .o_addr_grant(agnt), .o_data_buf_en(dbuf),
        .o_memory_chip_select(cs), .o_memory_read_strobe(mrd), .o_memory_write_strobe(mwr));

    fma_mem_model mem (.i_clk_sys(clk), .i_sys_rst(rst), .i_memory_chip_select(cs),
        .i_memory_read_strobe(mrd), .i_memory_write_strobe(mwr), .i_delay(mdly),
        .o_mem_ready(rdy));

    task check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check

    task results;
        $display("mismatches %0d, compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results

    task wait_grant(input logic exp, input int max, output logic hit);
        hit = 0;
        for (int i = 0; i < max && !hit; i++) begin
            @(negedge clk);
            hit = (egnt === exp);
        end
    endtask : wait_grant

    // Bounded wait for a done pulse; n reaches max on a hang
    task wait_done(input logic eng, input int max, output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (n < max && (eng ? edone : hdone) !== 1'b1);
    endtask : wait_done

    // Host keeps its request up after the access so calls chain into a series
    task host_acc(input logic wr, input logic reg_sel, output int n);
        seen_cs = 0; seen_rd = 0; seen_wr = 0;
        hreq = 1; hreg = reg_sel; hrd = !wr; hwr = wr;
        wait_done(0, 200, n);
        r_rw = wr ? rwr : rrd;
        check(n < 200, 1);
        hrd = 0; hwr = 0;
        @(negedge clk);
    endtask : host_acc

    // Watchers on every cycle; previous values kept for edge detection
    always @(negedge clk) begin
        if (!rst) begin
            check(agnt & dbuf, 1'b0);
            if ((mrd & !p_rd) | (mwr & !p_wr)) check(p_cs, 1'b1);
            if (egnt !== p_gnt) check(p_str, 1'b0);
        end
        seen_cs |= cs; seen_rd |= mrd; seen_wr |= mwr;
        p_gnt = egnt; p_cs = cs; p_rd = mrd; p_wr = mwr; p_str = mrd | mwr;
    end

    // Hang guard: the sequence needs a few hundred cycles at most
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            results();
        end
    end

    initial begin
        repeat (6) @(negedge clk);
        rst = 0;
        @(negedge clk);
        check({egnt, agnt}, 2'b00);
        // Each waitstate must lengthen a memory read
        for (int w = 0; w < 4; w++) begin
            ws = w[1:0];
            host_acc(0, 0, lat);
            check(lat >= w + 3, 1);
            if (w > 0) check(lat > lat_prev, 1);
            else lat0 = lat;
            check({seen_cs, seen_rd, seen_wr}, 3'b110);
            lat_prev = lat;
        end
        hreq = 0;
        @(negedge clk);
        ws = 2'h2;
        host_acc(1, 1, lat);
        check(lat >= 5, 1);
        check({seen_rd, seen_wr, r_rw}, 3'b001);
        host_acc(0, 1, lat);
        check(lat >= 5, 1);
        check({seen_cs, seen_rd, r_rw}, 3'b001);
        hreq = 0; hreg = 0; ws = 2'h0; mdly = 3'h4;
        @(negedge clk);
        host_acc(1, 0, lat);
        check(lat > lat0 + 2, 1);
        hreq = 0; mdly = 3'h0;
        // Strategy 0: engine series broken by the host
        ereq = 1;
        wait_grant(1, 10, ok);
        repeat (2) @(negedge clk);
        check({ok, agnt}, 2'b11);
        seen_wr = 0; eacc = 1; ewr = 1;
        repeat (2) @(negedge clk);
        hreq = 1;
        wait_done(1, 200, lat);
        check({lat < 200, seen_wr}, 2'b11);
        eacc = 0; ewr = 0;
        wait_grant(0, 10, ok);
        check(ok, 1);
        host_acc(0, 0, lat);
        wait_grant(1, 20, ok);
        check(ok, 0);
        hreq = 0;
        wait_grant(1, 10, ok);
        check(ok, 1);
        ereq = 0;
        wait_grant(0, 10, ok);
        check(ok, 1);
        // Strategy 1: engine outranks the host both ways
        strat = FMA_STRAT_ENG_PRIO; ereq = 1;
        wait_grant(1, 10, ok);
        hreq = 1; hrd = 1;
        wait_grant(0, 20, ok);
        check(ok, 0);
        ereq = 0;
        wait_done(0, 200, lat);
        check(lat < 200, 1);
        hrd = 0;
        @(negedge clk);
        ereq = 1;
        wait_grant(1, 10, ok);
        check(ok, 1);
        ereq = 0; hreq = 0;
        wait_grant(0, 10, ok);
        // Strategy 2: host lock, kept to a few accesses
        strat = FMA_STRAT_LOCK; ereq = 1;
        wait_grant(1, 30, ok);
        check(ok, 0);
        repeat (3) host_acc(0, 0, lat);
        hreq = 0; ereq = 0;
        @(negedge clk);
        // Strategy 3: only high priority transfers hold off the host
        strat = FMA_STRAT_MIXED; hreq = 1; ereq = 1;
        wait_grant(1, 20, ok);
        check(ok, 0);
        ehp = 1;
        wait_grant(1, 10, ok);
        check(ok, 1);
        wait_grant(0, 20, ok);
        check(ok, 0);
        ereq = 0; ehp = 0;
        wait_grant(0, 10, ok);
        check(ok, 1);
        hreq = 0;
        // Class 1: engine owns after reset and keeps it with no request
        cls1 = 1; rst = 1;
        repeat (6) @(negedge clk);
        rst = 0;
        repeat (2) @(negedge clk);
        check({egnt, agnt}, 2'b11);
        wait_grant(0, 20, ok);
        check(ok, 0);
        hreq = 1;
        wait_grant(0, 10, ok);
        check(ok, 1);
        results();
    end
endmodule : frame_memory_arbiter_test
